//--- hdl/cem_edge_sel.sv
// Clock source selector that turns a chosen clock level into a one-cycle enable, or enables every cycle for CEM_SRC_FREE
module cem_edge_sel
  import cem_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire cem_src_e sel,
  input wire logic [6:0] src,
  output logic en
);

  typedef struct packed {
    logic prev;
  } cem_edge_st_s;

  cem_edge_st_s s;
  cem_edge_st_s next_s;
  logic level;

  always_comb begin
    level = (sel == CEM_SRC_FREE) ? 1'b1 : src[sel];
    next_s.prev = level;
    en = (sel == CEM_SRC_FREE) ? 1'b1 : (level & ~s.prev);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

//--- hdl/cem_top.sv
// Configurable 2048-bit embedded memory block with optional registers and selectable clocks
//
// Chosen here: the Wishbone register port and the register offsets.
`include "cem_params.svh"
module cem_top
  import cem_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire cem_wb_req_s wb_req,
  output logic wb_ack,
  output logic [31:0] wb_dat,
  input wire logic [3:0] glb_sig,
  input wire logic [1:0] clk_pin,
  input wire logic usr_in_clk,
  input wire logic usr_out_clk,
  input wire logic [10:0] usr_addr,
  input wire logic [7:0] usr_din,
  input wire logic usr_we,
  output logic [7:0] usr_dout,
  output logic usr_hit
);

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [10:0] addr;
    logic we;
    logic [7:0] din;
    logic [7:0] dout;
    logic hit;
  } cem_top_st_s;

  cem_top_st_s s;
  cem_top_st_s next_s;

  // Storage: 256 rows of 8 bits, 2048 bits in all
  logic [7:0] mem [`CEM_ROWS];

  cem_cfg_s cfg;
  logic load_we;
  logic [7:0] load_row;
  logic [7:0] load_data;
  logic [31:0] status;
  logic [3:0] glb_s;
  logic [1:0] pin_s;
  logic in_en;
  logic out_en;
  logic [10:0] eff_addr;
  logic eff_we;
  logic sel_we;
  logic [7:0] eff_din;
  logic [10:0] bit_idx;
  logic [7:0] row;
  logic [2:0] off;
  logic [7:0] wmask;
  logic [2:0] upper;
  logic hit;
  logic wr_go;
  logic [7:0] raw_out;

  function automatic logic [7:0] shape_mask(input cem_shape_e sh);
    case (sh)
      CEM_SHAPE_256X8: shape_mask = 8'hFF;
      CEM_SHAPE_512X4: shape_mask = 8'h0F;
      CEM_SHAPE_1KX2: shape_mask = 8'h03;
      default: shape_mask = 8'h01;
    endcase
  endfunction

  cem_wb_regs u_regs (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .wb_req(wb_req),
    .wb_ack(wb_ack),
    .wb_dat(wb_dat),
    .cfg(cfg),
    .load_we(load_we),
    .load_row(load_row),
    .load_data(load_data),
    .row_rd(mem[load_row]),
    .status(status)
  );

  // Only the second stage of the pin synchronisers feeds logic
  assign glb_s = s.sync2[3:0];
  assign pin_s = s.sync2[5:4];

  // Input and output sides each pick their own clock source
  cem_edge_sel u_in_sel (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .sel(cfg.in_src),
    .src({usr_in_clk, pin_s, glb_s}),
    .en(in_en)
  );

  cem_edge_sel u_out_sel (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .sel(cfg.out_src),
    .src({usr_out_clk, pin_s, glb_s}),
    .en(out_en)
  );

  always_comb begin
    // Write strobe from a global signal or from user routing
    sel_we = cfg.we_glob ? glb_s[cfg.we_gsel] : usr_we;
    // Address and strobe registers share reg_addr; the data register is used or bypassed on its own
    eff_addr = cfg.reg_addr ? s.addr : usr_addr;
    eff_we = cfg.reg_addr ? s.we : sel_we;
    eff_din = cfg.reg_din ? s.din : usr_din;
    // Only log2(depth) address bits index the array
    case (cfg.shape)
      CEM_SHAPE_256X8: begin
        bit_idx = {eff_addr[7:0], 3'b000};
        upper = eff_addr[10:8];
      end
      CEM_SHAPE_512X4: begin
        bit_idx = {eff_addr[8:0], 2'b00};
        upper = {1'b0, eff_addr[10:9]};
      end
      CEM_SHAPE_1KX2: begin
        bit_idx = {eff_addr[9:0], 1'b0};
        upper = {2'b00, eff_addr[10]};
      end
      default: begin
        bit_idx = eff_addr;
        upper = 3'b000;
      end
    endcase
    row = bit_idx[10:3];
    off = bit_idx[2:0];
    wmask = shape_mask(cfg.shape);
    // Upper address bits select one block of a depth cascade
    hit = (upper == cfg.blk_sel);
    // Write pulse is made here on the input edge; no user pulse timing
    wr_go = in_en & eff_we & hit & ~cfg.rom_mode;
    // Read result is masked to the word width
    raw_out = hit ? ((mem[row] >> off) & wmask) : 8'h00;
  end

  always_comb begin
    next_s = s;
    next_s.sync1 = {clk_pin, glb_sig};
    next_s.sync2 = s.sync1;
    if (in_en) begin
      next_s.addr = usr_addr;
      next_s.we = sel_we;
      next_s.din = usr_din;
    end
    // Output register updates on the output edge, bypass follows every cycle
    if (!cfg.reg_dout || out_en) begin
      next_s.dout = raw_out;
      next_s.hit = hit;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Loader fills contents at configuration time for lookup use
  always_ff @(posedge ref_clk) begin
    if (wr_go) begin
      mem[row] <= (mem[row] & ~(wmask << off)) | ((eff_din & wmask) << off);
    end
    if (load_we) begin
      mem[load_row] <= load_data;
    end
  end

  assign status = {12'h000, eff_addr, s.hit, s.dout};
  // Unselected blocks drive zero, so side-by-side or cascaded outputs can be ORed
  assign usr_dout = s.dout;
  assign usr_hit = s.hit;

  logic [7:0] past_row;
  logic [7:0] past_wdata;
  logic [7:0] past_wbits;
  logic past_wr;
  logic past_clash;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      past_row <= 8'h00;
      past_wdata <= 8'h00;
      past_wbits <= 8'h00;
      past_wr <= 1'b0;
      past_clash <= 1'b0;
    end else begin
      past_row <= row;
      past_wdata <= (eff_din & wmask) << off;
      past_wbits <= wmask << off;
      past_wr <= wr_go;
      past_clash <= load_we && (load_row == row);
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_write_edge;
    in_en && eff_we && hit && !cfg.rom_mode;
  endsequence

  // A loader write to the same row wins, so the user word need not be there
  sequence s_word_stored;
    past_wr ##0 (past_clash || ((mem[past_row] & past_wbits) == past_wdata));
  endsequence

  property p_write_store;
    s_write_edge |=> s_word_stored;
  endproperty
  a_write_store: assert property (p_write_store)
    else $error("Written word not found in storage");

  // Without an input edge or a loader write the array must not change
  property p_write_needs_edge;
    !in_en && !load_we |=> mem[$past(row)] === $past(mem[row]);
  endproperty
  a_write_needs_edge: assert property (p_write_needs_edge)
    else $error("Write occurred without an input clock edge");

  property p_rom_no_write;
    cfg.rom_mode && !load_we |=> mem[$past(row)] === $past(mem[row]);
  endproperty
  a_rom_no_write: assert property (p_rom_no_write)
    else $error("User write changed read-only contents");

  property p_dout_hold;
    cfg.reg_dout && !out_en ##1 cfg.reg_dout |-> $stable(usr_dout);
  endproperty
  a_dout_hold: assert property (p_dout_hold)
    else $error("Registered output changed without an output edge");

  property p_dout_bypass;
    !cfg.reg_dout |=> usr_dout === $past(raw_out);
  endproperty
  a_dout_bypass: assert property (p_dout_bypass)
    else $error("Bypassed output does not follow the array");

  property p_width_mask;
    !cfg.reg_dout || out_en |=> (usr_dout & ~shape_mask($past(cfg.shape))) == 8'h00;
  endproperty
  a_width_mask: assert property (p_width_mask)
    else $error("Output bits above the word width are set");

  property p_miss_zero;
    !usr_hit |-> usr_dout == 8'h00;
  endproperty
  a_miss_zero: assert property (p_miss_zero)
    else $error("Unselected block drives data");

  property p_free_clock;
    cfg.in_src == CEM_SRC_FREE |-> in_en;
  endproperty
  a_free_clock: assert property (p_free_clock)
    else $error("Free-running input clock gave no enable");

  property p_addr_capture;
    in_en && cfg.reg_addr ##1 cfg.reg_addr |-> eff_addr == $past(usr_addr);
  endproperty
  a_addr_capture: assert property (p_addr_capture)
    else $error("Address register did not capture on the input edge");

  property p_glob_we;
    cfg.we_glob && !cfg.reg_addr && !glb_s[cfg.we_gsel] |-> !wr_go;
  endproperty
  a_glob_we: assert property (p_glob_we)
    else $error("Write without the selected global strobe");

  property p_wb_ack;
    wb_req.cyc && wb_req.stb && !wb_ack |=> wb_ack ##1 !wb_ack;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("Bus acknowledge not a single cycle after request");

endmodule

//--- hdl/cem_wb_regs.sv
// Wishbone slave holding the configuration, status window and contents loader
`include "cem_params.svh"
module cem_wb_regs
  import cem_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire cem_wb_req_s wb_req,
  output logic wb_ack,
  output logic [31:0] wb_dat,
  output cem_cfg_s cfg,
  output logic load_we,
  output logic [7:0] load_row,
  output logic [7:0] load_data,
  input wire logic [7:0] row_rd,
  input wire logic [31:0] status
);

  typedef struct packed {
    cem_cfg_s cfg;
    logic [7:0] row;
    logic ack;
    logic [31:0] dat;
  } cem_wb_st_s;

  cem_wb_st_s s;
  cem_wb_st_s next_s;
  logic [31:0] lane_mask;
  logic take;
  logic [31:0] cfg_wide;
  logic [31:0] cfg_wr;

  // Byte lanes follow sel
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_lane
      assign lane_mask[8*i +: 8] = {8{wb_req.sel[i]}};
    end
  endgenerate

  assign take = wb_req.cyc & wb_req.stb & ~s.ack;
  assign cfg_wide = {14'h0000, s.cfg};
  // Byte-lane merge of a configuration write; only the low field bits are kept
  assign cfg_wr = (cfg_wide & ~lane_mask) | (wb_req.dat & lane_mask);

  always_comb begin
    next_s = s;
    next_s.ack = take;
    load_we = 1'b0;
    if (take && wb_req.we) begin
      case (wb_req.adr)
        `CEM_OFF_CFG: next_s.cfg = cem_cfg_s'(cfg_wr[`CEM_CFG_W-1:0]);
        `CEM_OFF_LOAD_ADDR: if (wb_req.sel[0]) next_s.row = wb_req.dat[7:0];
        `CEM_OFF_LOAD_DATA: begin
          load_we = wb_req.sel[0];
          if (wb_req.sel[0]) next_s.row = s.row + 8'h01;
        end
        default: next_s.row = s.row;
      endcase
    end
    if (take && !wb_req.we) begin
      case (wb_req.adr)
        `CEM_OFF_CFG: next_s.dat = cfg_wide;
        `CEM_OFF_STATUS: next_s.dat = status;
        `CEM_OFF_LOAD_ADDR: next_s.dat = {24'h000000, s.row};
        `CEM_OFF_LOAD_DATA: next_s.dat = {24'h000000, row_rd};
        default: next_s.dat = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s.cfg <= cem_cfg_s'(`CEM_CFG_RESET);
      s.row <= 8'h00;
      s.ack <= 1'b0;
      s.dat <= 32'h00000000;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack = s.ack;
  assign wb_dat = s.dat;
  assign cfg = s.cfg;
  assign load_row = s.row;
  assign load_data = wb_req.dat[7:0];

endmodule

//--- shared/cem_params.svh
// Register offsets, field positions and reset values of the embedded memory block
`ifndef CEM_PARAMS_SVH
`define CEM_PARAMS_SVH

`define CEM_ADR_W 4
`define CEM_OFF_CFG 4'h0
`define CEM_OFF_STATUS 4'h4
`define CEM_OFF_LOAD_ADDR 4'h8
`define CEM_OFF_LOAD_DATA 4'hC

`define CEM_CFG_W 18
`define CEM_CFG_RESET 18'h07E1C

`define CEM_STAT_DOUT_LSB 0
`define CEM_STAT_HIT_BIT 8
`define CEM_STAT_ADDR_LSB 9

`define CEM_TOTAL_BITS 2048
`define CEM_ROWS 256
`define CEM_ROW_W 8
`define CEM_ADDR_W 11
`define CEM_SYNC_W 6

`endif

//--- shared/cem_pkg.sv
// Types shared by the embedded memory block modules
package cem_pkg;

  typedef enum logic [1:0] {
    CEM_SHAPE_256X8 = 2'b00,
    CEM_SHAPE_512X4 = 2'b01,
    CEM_SHAPE_1KX2 = 2'b10,
    CEM_SHAPE_2KX1 = 2'b11
  } cem_shape_e;

  // Clock source: 0-3 global signals, 4-5 dedicated pins, 6 local routing, 7 every cycle
  typedef enum logic [2:0] {
    CEM_SRC_GLB0 = 3'b000, CEM_SRC_GLB1 = 3'b001, CEM_SRC_GLB2 = 3'b010,
    CEM_SRC_GLB3 = 3'b011, CEM_SRC_PIN0 = 3'b100, CEM_SRC_PIN1 = 3'b101,
    CEM_SRC_LOCAL = 3'b110, CEM_SRC_FREE = 3'b111
  } cem_src_e;

  typedef struct packed {
    logic [2:0] blk_sel;
    cem_src_e out_src;
    cem_src_e in_src;
    logic [1:0] we_gsel;
    logic we_glob;
    logic rom_mode;
    logic reg_dout;
    logic reg_addr;
    logic reg_din;
    cem_shape_e shape;
  } cem_cfg_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } cem_wb_req_s;

endpackage

//--- sim/cem_user_logic.sv
// User-logic partner driving address, data, strobe and clock levels
module cem_user_logic (
  input wire logic ref_clk,
  output logic [10:0] usr_addr,
  output logic [7:0] usr_din,
  output logic usr_we,
  output logic usr_in_clk,
  output logic usr_out_clk,
  output logic [3:0] glb_sig,
  output logic [1:0] clk_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    usr_addr = '0;
    usr_din = '0;
    usr_we = 1'b0;
    usr_in_clk = 1'b0;
    usr_out_clk = 1'b0;
    glb_sig = '0;
    clk_pin = '0;
  end
  // Change after an edge and hold across n edges, then let synced strobes settle
  task automatic put(input logic [10:0] a, input logic [7:0] d, input logic w,
                     input logic g, input int n);
    @(posedge ref_clk);
    usr_addr <= a;
    usr_din <= d;
    usr_we <= w;
    glb_sig[0] <= g;
    repeat (n) @(posedge ref_clk);
    usr_we <= 1'b0;
    glb_sig[0] <= 1'b0;
    repeat (3) @(posedge ref_clk);
    // Stale data is not left on the lines
    usr_din <= ~d;
  endtask
  // One clock pulse: 1 input level, 2 output level, otherwise dedicated pin 0
  task automatic pulse(input int k);
    @(posedge ref_clk);
    case (k)
      1: usr_in_clk <= 1'b1;
      2: usr_out_clk <= 1'b1;
      default: clk_pin[0] <= 1'b1;
    endcase
    repeat (2) @(posedge ref_clk);
    usr_in_clk <= 1'b0;
    usr_out_clk <= 1'b0;
    clk_pin[0] <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the embedded memory block
`include "cem_params.svh"
module tb_top
  import cem_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk;
  logic rstn;
  cem_wb_req_s wb_req;
  logic wb_ack;
  logic [31:0] wb_dat;
  logic [3:0] glb_sig;
  logic [1:0] clk_pin;
  logic usr_in_clk;
  logic usr_out_clk;
  logic [10:0] usr_addr;
  logic [7:0] usr_din;
  logic usr_we;
  logic [7:0] usr_dout;
  logic usr_hit;
  int n_mismatch = 0;
  int comparisons = 0;

  cem_top uut (
    .ref_clk(ref_clk), .rstn(rstn), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat(wb_dat),
    .glb_sig(glb_sig), .clk_pin(clk_pin), .usr_in_clk(usr_in_clk), .usr_out_clk(usr_out_clk),
    .usr_addr(usr_addr), .usr_din(usr_din), .usr_we(usr_we), .usr_dout(usr_dout),
    .usr_hit(usr_hit)
  );
  cem_user_logic um (
    .ref_clk(ref_clk), .usr_addr(usr_addr), .usr_din(usr_din), .usr_we(usr_we),
    .usr_in_clk(usr_in_clk), .usr_out_clk(usr_out_clk), .glb_sig(glb_sig),
    .clk_pin(clk_pin)
  );

  always #4 ref_clk = ~ref_clk;

  task automatic close_out();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] adr, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    q = '0;
    @(posedge ref_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: adr, sel: 4'hF, dat: d};
    // Hold the request until ack is sampled high at a rising edge
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (wb_ack !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t bus answer missing", $time);
      close_out();
    end else begin
      q = wb_dat;
      wb_req <= '0;
      @(posedge ref_clk);
    end
  endtask

  task automatic set_cfg(input logic [31:0] v);
    logic [31:0] q;
    wb(1'b1, `CEM_OFF_CFG, v, q);
  endtask

  // Present an address, optionally pulse a clock line (1 in, 2 out, 3 pin), judge the read
  task automatic rd(input logic [10:0] a, input logic [7:0] e, input logic h,
                    input int p);
    um.put(a, 8'h00, 1'b0, 1'b0, 2);
    if (p != 0) begin
      um.pulse(p);
    end
    #1;
    chk({24'h0, usr_dout}, {24'h0, e});
    chk({31'h0, usr_hit}, {31'h0, h});
  endtask

  task automatic t_regs();
    logic [31:0] q;
    wb(1'b0, `CEM_OFF_CFG, '0, q);
    chk(q, 32'(`CEM_CFG_RESET));
    wb(1'b0, 4'h2, '0, q);
    chk(q, 32'h0);
  endtask

  task automatic t_walk();
    um.put(11'd20, 8'h6B, 1'b1, 1'b0, 1);
    rd(11'd20, 8'h6B, 1'b1, 1'b0);
    set_cfg(32'h7E00);
    um.put(11'd5, 8'hAA, 1'b1, 1'b0, 1);
    rd(11'd5, 8'hAA, 1'b1, 1'b0);
  endtask

  task automatic t_shapes();
    logic [10:0] a;
    for (int s = 0; s < 4; s++) begin
      set_cfg(32'h7E00 | 32'(s));
      a = 11'((256 << s) - 1);
      um.put(a, 8'hFF, 1'b1, 1'b0, 1);
      um.put(a - 11'd1, 8'h00, 1'b1, 1'b0, 1);
      rd(a, 8'((1 << (8 >> s)) - 1), 1'b1, 1'b0);
    end
  endtask

  task automatic t_sel();
    set_cfg(32'h7E00 | 32'h8000);
    um.put(11'd259, 8'h5C, 1'b1, 1'b0, 1);
    rd(11'd259, 8'h5C, 1'b1, 1'b0);
    rd(11'd3, 8'h00, 1'b0, 1'b0);
  endtask

  task automatic t_rom();
    logic [31:0] q;
    set_cfg(32'h7E00);
    wb(1'b1, `CEM_OFF_LOAD_ADDR, 32'h9, q);
    wb(1'b1, `CEM_OFF_LOAD_DATA, 32'h3C, q);
    wb(1'b0, `CEM_OFF_LOAD_ADDR, '0, q);
    chk(q, 32'h0000000A);
    wb(1'b1, `CEM_OFF_LOAD_ADDR, 32'h9, q);
    wb(1'b0, `CEM_OFF_LOAD_DATA, '0, q);
    chk(q, 32'h0000003C);
    set_cfg(32'h7E20);
    um.put(11'd9, 8'hFF, 1'b1, 1'b0, 1);
    rd(11'd9, 8'h3C, 1'b1, 1'b0);
    wb(1'b0, `CEM_OFF_STATUS, '0, q);
    chk(q, (32'd9 << `CEM_STAT_ADDR_LSB) | (32'd1 << `CEM_STAT_HIT_BIT) | 32'h3C);
  endtask

  task automatic t_glb();
    set_cfg(32'h7E40);
    um.put(11'd12, 8'h11, 1'b0, 1'b1, 4);
    rd(11'd12, 8'h11, 1'b1, 1'b0);
    um.put(11'd12, 8'h99, 1'b1, 1'b0, 4);
    rd(11'd12, 8'h11, 1'b1, 1'b0);
  endtask

  // Input side on the user clock level: one write per rising level, none without it
  task automatic t_iclk();
    set_cfg(32'h7C00);
    fork
      um.put(11'd30, 8'h77, 1'b1, 1'b0, 4);
      um.pulse(1);
    join
    rd(11'd30, 8'h77, 1'b1, 0);
    um.put(11'd30, 8'h12, 1'b1, 1'b0, 4);
    rd(11'd30, 8'h77, 1'b1, 0);
  endtask

  task automatic t_oreg();
    set_cfg(32'h6E10);
    um.put(11'd7, 8'h5A, 1'b1, 1'b0, 1);
    rd(11'd7, 8'h5A, 1'b1, 2);
    um.put(11'd8, 8'hC3, 1'b1, 1'b0, 1);
    rd(11'd8, 8'h5A, 1'b1, 1'b0);
    rd(11'd8, 8'hC3, 1'b1, 2);
  endtask

  // Output register clocked from dedicated pin 0 through its synchroniser
  task automatic t_pins();
    set_cfg(32'h4E10);
    um.put(11'd40, 8'h81, 1'b1, 1'b0, 1);
    rd(11'd40, 8'hC3, 1'b1, 0);
    rd(11'd40, 8'h81, 1'b1, 3);
  endtask

  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    wb_req = '0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    t_regs();
    t_walk();
    t_shapes();
    t_sel();
    t_rom();
    t_glb();
    t_iclk();
    t_oreg();
    t_pins();
    close_out();
  end
endmodule
